// ===== include/jtap_pkg.sv
// jtap_pkg: constants, states and carrier types of the test access port.
// assumes: shared by the port logic and the bench only.
`default_nettype none
package jtap_pkg;
   localparam int unsigned IR_W = 3;
   localparam int unsigned ID_W = 32;
   localparam int unsigned BSR_W = 107;
   localparam int unsigned OE_CELL = 47;
   ////////////////////////////////////////////////////////////////////////
   // instruction codes, capture patterns and reset values
   localparam logic [2:0] IR_EXTEST = 3'h0;
   localparam logic [2:0] IR_IDCODE = 3'h1;
   localparam logic [2:0] IR_SAMPLEZ = 3'h2;
   localparam logic [2:0] IR_SAMPLE = 3'h4;
   localparam logic [2:0] IR_BYPASS = 3'h7;
   localparam logic [2:0] IR_CAPT = 3'h1;
   localparam logic [2:0] IR_RST = IR_IDCODE;
   localparam logic BYP_CAPT = 1'b0;
   localparam logic OE_CELL_RST = 1'b1;
   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [3:0] {
      ST_TLR = 4'h0, ST_RTI = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
      ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PA_DR = 4'h6, ST_EX2_DR = 4'h7,
      ST_UP_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'ha, ST_SH_IR = 4'hb,
      ST_EX1_IR = 4'hc, ST_PA_IR = 4'hd, ST_EX2_IR = 4'he, ST_UP_IR = 4'hf
   } jtap_state_t;
   // identification word layout, msb first
   typedef struct packed {
      logic [2:0] rev;
      logic [16:0] part;
      logic [10:0] maker;
      logic present;
   } jtap_id_t;
   // synchronised link pins
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } jtap_link_t;
   function automatic logic jtap_sel_bsr(input logic [2:0] ir);
      jtap_sel_bsr = (ir == IR_EXTEST) || (ir == IR_SAMPLEZ) ||
                     (ir == IR_SAMPLE);
   endfunction : jtap_sel_bsr
endpackage : jtap_pkg
`default_nettype wire

// ===== logic/jtap_top.sv
// jtap_top: boundary-scan test access port, oversampling the link on clk_i.
// assumes: clk_i at least 4x the link clock; pins_i stable around capture.
//
// Contract
// [R01] next tap state follows tms sampled at each link clock rise
// [R02] tdi shifts into the selected register on the link clock rise
// [R03] tdo changes only after a link clock fall
// [R04] lengths: instruction 3, bypass 1, identity 32, pin chain 107
// [R05] code 000 captures pin ring and shifts the pin chain
// [R06] code 001 captures the fixed identity word and shifts it
// [R07] code 010 captures pins, shifts pin chain, floats memory outputs
// [R08] code 100 captures pins, shifts pin chain, memory undisturbed
// [R09] code 111 puts the one-bit skip register between tdi and tdo
// [R10] controller never loads reserved codes 011, 101, 110; update-ir loads them here, and tdo then reads the skip register
// [R11] identity bits 31:29 revision, bits 11:1 maker code
// [R12] identity bits 28:12 carry the part code
// [R13] identity bit 0 always reads one
// [R14] instruction holds identity code after reset and in test-logic-reset
// [R15] capture-ir loads 01 into the two low instruction bits
// [R16] latched cell 47 enables output drivers under code 000; presets high
// [R17] pin chain msb next to tdi, lsb next to tdo
// [R18] standard sixteen states; five tms ones reach test-logic-reset
`timescale 1ns/1ps
`default_nettype none
module jtap_top
   import jtap_pkg::*;
#(
   parameter logic [2:0] ID_REV = 3'h1,       // arbitrary value
   parameter logic [16:0] ID_PART = 17'h0abcd, // arbitrary value
   parameter logic [10:0] ID_MAKER = 11'h05a   // arbitrary value
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // test link
   input wire logic tck_i,
   input wire logic tms_i,
   input wire logic tdi_i,
   output logic tdo_o,
   output logic tdo_oe_o,
   // pin ring
   input wire logic [BSR_W-1:0] pins_i,
   output logic [BSR_W-1:0] bsr_drive_o,
   output logic extest_o,
   output logic q_drive_en_o
);
   ////////////////////////////////////////////////////////////////////////
   // reset release and link synchronisers
   logic [1:0] rst_q;
   logic rst_n;
   jtap_link_t lnk_s1_q, lnk_s2_q;
   logic tck_s3_q;
   logic [BSR_W-1:0] pin_s1_q, pin_s2_q;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) rst_q <= 2'h0;
      else rst_q <= {rst_q[0], 1'b1};
   end
   assign rst_n = rst_q[1];
   // every check below samples on clk_i and sleeps while in reset
   default clocking cb_chk @(posedge clk_i);
   endclocking
   default disable iff (!rst_n);

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         lnk_s1_q <= '0;
         lnk_s2_q <= '0;
         tck_s3_q <= 1'b0;
      end else begin
         lnk_s1_q <= '{tck: tck_i, tms: tms_i, tdi: tdi_i};
         lnk_s2_q <= lnk_s1_q;
         tck_s3_q <= lnk_s2_q.tck;
      end
   end

   // pin ring sampled for capture only; metastability is the tester's risk
   always_ff @(posedge clk_i) begin
      pin_s1_q <= pins_i;
      pin_s2_q <= pin_s1_q;
   end

   logic tck_rise, tck_fall, tms, tdi;
   assign tck_rise = lnk_s2_q.tck & ~tck_s3_q;
   assign tck_fall = ~lnk_s2_q.tck & tck_s3_q;
   assign tms = lnk_s2_q.tms;
   assign tdi = lnk_s2_q.tdi;

   ////////////////////////////////////////////////////////////////////////
   // tap controller
   jtap_state_t state_q, state_d;

   always_comb begin
      case (state_q)
         ST_TLR: state_d = tms ? ST_TLR : ST_RTI;
         ST_RTI: state_d = tms ? ST_SEL_DR : ST_RTI;
         ST_SEL_DR: state_d = tms ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: state_d = tms ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR: state_d = tms ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: state_d = tms ? ST_UP_DR : ST_PA_DR;
         ST_PA_DR: state_d = tms ? ST_EX2_DR : ST_PA_DR;
         ST_EX2_DR: state_d = tms ? ST_UP_DR : ST_SH_DR;
         ST_UP_DR: state_d = tms ? ST_SEL_DR : ST_RTI;
         ST_SEL_IR: state_d = tms ? ST_TLR : ST_CAP_IR;
         ST_CAP_IR: state_d = tms ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR: state_d = tms ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: state_d = tms ? ST_UP_IR : ST_PA_IR;
         ST_PA_IR: state_d = tms ? ST_EX2_IR : ST_PA_IR;
         ST_EX2_IR: state_d = tms ? ST_UP_IR : ST_SH_IR;
         ST_UP_IR: state_d = tms ? ST_SEL_DR : ST_RTI;
         default: state_d = ST_TLR;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) state_q <= ST_TLR;
      else if (tck_rise) state_q <= state_d; // R01 R18
   end

   ////////////////////////////////////////////////////////////////////////
   // scan registers
   logic [IR_W-1:0] ir_sh_q, ir_q;
   logic byp_q;
   logic [ID_W-1:0] id_sh_q;
   logic [BSR_W-1:0] bsr_sh_q, bsr_up_q;
   jtap_id_t id_word;
   logic sel_bsr, cap_dr, sh_dr, cap_ir, sh_ir, in_tlr;

   assign id_word = '{rev: ID_REV, part: ID_PART, maker: ID_MAKER,
                      present: 1'b1}; // R11 R12 R13
   assign sel_bsr = jtap_sel_bsr(ir_q);
   assign cap_dr = tck_rise && (state_q == ST_CAP_DR);
   assign sh_dr = tck_rise && (state_q == ST_SH_DR);
   assign cap_ir = tck_rise && (state_q == ST_CAP_IR);
   assign sh_ir = tck_rise && (state_q == ST_SH_IR);
   assign in_tlr = (state_q == ST_TLR);

   // instruction path; reserved codes fall to the skip register
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ir_sh_q <= IR_CAPT;
         ir_q <= IR_RST;
      end else begin
         if (cap_ir) ir_sh_q <= IR_CAPT; // R15
         else if (sh_ir) ir_sh_q <= {tdi, ir_sh_q[IR_W-1:1]}; // R02 R04
         if (in_tlr) ir_q <= IR_RST; // R14
         else if (tck_fall && state_q == ST_UP_IR) ir_q <= ir_sh_q;
      end
   end

   // data registers shift lsb first toward tdo
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         byp_q <= BYP_CAPT;
         id_sh_q <= '0;
         bsr_sh_q <= '0;
      end else begin
         if (cap_dr) begin
            byp_q <= BYP_CAPT; // R09
            if (ir_q == IR_IDCODE) id_sh_q <= id_word; // R06
            if (sel_bsr) bsr_sh_q <= pin_s2_q; // R05 R07 R08
         end else if (sh_dr) begin
            byp_q <= tdi; // R02
            if (ir_q == IR_IDCODE) id_sh_q <= {tdi, id_sh_q[ID_W-1:1]};
            if (sel_bsr) bsr_sh_q <= {tdi, bsr_sh_q[BSR_W-1:1]}; // R17
         end
      end
   end

   // update latches on the falling edge, as the standard cells do
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         bsr_up_q <= '0;
         bsr_up_q[OE_CELL] <= OE_CELL_RST;
      end else if (in_tlr) begin
         bsr_up_q[OE_CELL] <= OE_CELL_RST; // R16
      end else if (tck_fall && state_q == ST_UP_DR && sel_bsr) begin
         bsr_up_q <= bsr_sh_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // tdo and pin ring outputs
   logic tdo_q, tdo_oe_q, tdo_d;
   always_comb begin
      if (state_q == ST_SH_IR) tdo_d = ir_sh_q[0];
      else if (sel_bsr) tdo_d = bsr_sh_q[0];
      else if (ir_q == IR_IDCODE) tdo_d = id_sh_q[0];
      else tdo_d = byp_q; // R09
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         tdo_q <= 1'b0;
         tdo_oe_q <= 1'b0;
      end else if (tck_fall) begin
         tdo_q <= tdo_d; // R03
         tdo_oe_q <= (state_q == ST_SH_DR) || (state_q == ST_SH_IR);
      end
   end

   assign tdo_o = tdo_q;
   assign tdo_oe_o = tdo_oe_q;
   assign bsr_drive_o = bsr_up_q;
   assign extest_o = (ir_q == IR_EXTEST); // R05
   // floating under 010, and under 000 when the latched cell is low
   assign q_drive_en_o = (ir_q != IR_SAMPLEZ) &&
                         !(extest_o && !bsr_up_q[OE_CELL]); // R07 R16

   ////////////////////////////////////////////////////////////////////////
   // checks
   logic [2:0] ones_q;
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) ones_q <= 3'h0;
      else if (tck_rise) ones_q <= !tms ? 3'h0 :
                                   (ones_q == 3'h5) ? 3'h5 : ones_q + 3'h1;
   end

   a_tms_next_state: assert property ( // R01
      tck_rise && state_q == ST_TLR && !tms |=> state_q == ST_RTI)
      else $error("tms low in reset did not reach idle");
   a_bsr_tdi_shift: assert property ( // R02
      sh_dr && sel_bsr |=> bsr_sh_q[BSR_W-1] == $past(tdi))
      else $error("tdi not shifted into pin chain msb");
   a_tdo_after_fall: assert property ( // R03
      $changed(tdo_q) |-> $past(tck_fall))
      else $error("tdo changed without a link clock fall");
   a_ir_shift_len: assert property ( // R04
      sh_ir |=> ir_sh_q == {$past(tdi), $past(ir_sh_q[2:1])})
      else $error("instruction shift wrong");
   a_extest_capture: assert property ( // R05
      cap_dr && ir_q == IR_EXTEST |=> bsr_sh_q == $past(pin_s2_q))
      else $error("pin ring not captured");
   a_idcode_capture: assert property ( // R06
      cap_dr && ir_q == IR_IDCODE |=> id_sh_q == id_word && id_sh_q[0])
      else $error("identity word not captured");
   a_samplez_float: assert property ( // R07
      ir_q == IR_SAMPLEZ |-> !q_drive_en_o)
      else $error("outputs driven under float sample");
   a_sample_drive: assert property ( // R08
      ir_q == IR_SAMPLE |-> q_drive_en_o)
      else $error("outputs disturbed under sample");
   a_bypass_capture: assert property ( // R09
      cap_dr ##1 (ir_q == IR_BYPASS) |-> !byp_q)
      else $error("skip register not cleared at capture");
   a_tlr_preset: assert property (@(posedge clk_i) disable iff (!rst_n) // R14
      in_tlr |=> ir_q == IR_IDCODE && bsr_up_q[OE_CELL])
      else $error("reset state did not restore instruction");
   a_capture_ir: assert property (@(posedge clk_i) disable iff (!rst_n) // R15
      cap_ir |=> ir_sh_q[1:0] == 2'b01)
      else $error("capture-ir pattern wrong");
   a_extest_float: assert property ( // R16
      extest_o && !bsr_up_q[OE_CELL] |-> !q_drive_en_o)
      else $error("outputs driven with cell 47 low");
   a_five_ones: assert property (@(posedge clk_i) disable iff (!rst_n) // R18
      ones_q == 3'h5 |-> in_tlr)
      else $error("five tms ones did not reach reset");
   a_id_rev_maker: assert property ( // R11
      cap_dr && ir_q == IR_IDCODE |=>
         id_sh_q[31:29] == ID_REV && id_sh_q[11:1] == ID_MAKER)
      else $error("identity revision or maker field wrong");
   a_id_part_code: assert property ( // R12
      cap_dr && ir_q == IR_IDCODE |=> id_sh_q[28:12] == ID_PART)
      else $error("identity part field wrong");
   a_id_present: assert property ( // R13
      cap_dr && ir_q == IR_IDCODE |=> id_sh_q[0])
      else $error("identity presence bit low");
   a_bsr_toward_tdo: assert property ( // R17
      sh_dr && sel_bsr |=> bsr_sh_q[BSR_W-2:0] == $past(bsr_sh_q[BSR_W-1:1]))
      else $error("pin chain did not move toward tdo");
   a_tdo_from_lsb: assert property ( // R17
      tck_fall && state_q == ST_SH_DR && sel_bsr |=>
         tdo_q == $past(bsr_sh_q[0]))
      else $error("tdo not fed from pin chain lsb");
   a_idcode_drive: assert property ( // R06
      ir_q == IR_IDCODE |-> q_drive_en_o)
      else $error("outputs disturbed under identity code");
   a_bypass_drive: assert property ( // R09
      ir_q == IR_BYPASS |-> q_drive_en_o)
      else $error("outputs disturbed under skip code");
   a_bypass_shift: assert property ( // R09
      sh_dr && ir_q == IR_BYPASS |=> byp_q == $past(tdi))
      else $error("skip register did not take tdi");
   a_tdo_oe_shift: assert property ( // R03
      tck_fall && state_q == ST_SH_DR |=> tdo_oe_q)
      else $error("tdo not enabled in shift");
   a_state_hold: assert property ( // R01
      !tck_rise |=> $stable(state_q))
      else $error("tap state moved without a link clock rise");
   a_dr_update: assert property ( // R16
      tck_fall && state_q == ST_UP_DR && sel_bsr |=>
         bsr_up_q == $past(bsr_sh_q))
      else $error("pin chain not latched at update");

   c_ir_update: cover property (@(posedge clk_i) disable iff (!rst_n)
      tck_fall && state_q == ST_UP_IR);
   c_extest_float: cover property (@(posedge clk_i) disable iff (!rst_n)
      extest_o && !q_drive_en_o);
   c_id_shift: cover property (@(posedge clk_i) disable iff (!rst_n)
      sh_dr && ir_q == IR_IDCODE);
   c_bypass_shift: cover property (
      sh_dr && ir_q == IR_BYPASS);
   c_tlr_by_tms: cover property (
      tck_rise && state_q == ST_SEL_IR && tms);
endmodule : jtap_top
`default_nettype wire

// ===== tb/jtap_tester.sv
// jtap_tester: model of the external boundary-scan controller.
// assumes: clk_i is the bench clock; one link period is 8 clk_i cycles.
`timescale 1ns/1ps
`default_nettype none
module jtap_tester
   import jtap_pkg::*;
(
   // bench clock
   input wire logic clk_i,
   // test link
   input wire logic tdo_i,
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o
);
   // link clock stands low between frames
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   // 5 clk low, 3 clk high; tdo read just before the fall, still stable
   task automatic tick(input logic tms, input logic tdi, output logic tdo);
      @(posedge clk_i);
      tms_o <= tms;
      tdi_o <= tdi;
      repeat (4) @(posedge clk_i);
      tck_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      tdo = tdo_i;
      tck_o <= 1'b0;
   endtask : tick
   task automatic to_idle();
      logic d;
      repeat (5) tick(1'b1, 1'b0, d);
      tick(1'b0, 1'b0, d);
   endtask : to_idle
   // idle to idle; bits lsb first, tdi inverted once released
   task automatic scan(input logic ir, input int n, input logic [127:0] din,
                       output logic [127:0] dout);
      logic d;
      dout = '0;
      tick(1'b1, 1'b0, d);
      if (ir) tick(1'b1, 1'b0, d);
      tick(1'b0, 1'b0, d);
      tick(1'b0, 1'b0, d);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, din[i], d);
         dout[i] = d;
      end
      tick(1'b1, ~din[n-1], d);
      tick(1'b0, din[n-1], d);
   endtask : scan
   task automatic load_ir(input logic [2:0] code, output logic [2:0] capt);
      logic [127:0] o;
      // reserved codes are never sent; bypass stands in for them
      if (code inside {3'h3, 3'h5, 3'h6}) code = IR_BYPASS;
      scan(1'b1, IR_W, {125'h0, code}, o);
      capt = o[2:0];
   endtask : load_ir
endmodule : jtap_tester
`default_nettype wire

// ===== tb/jtap_top_tb.sv
// jtap_top_tb: drives the test access port through the tester model.
// assumes: identity fields set here at the instance.
`timescale 1ns/1ps
`default_nettype none
module jtap_top_tb;
   import jtap_pkg::*;
   localparam logic [2:0] REV = 3'h5; // arbitrary value
   localparam logic [16:0] PART = 17'h1c3a5; // arbitrary value
   localparam logic [10:0] MAKER = 11'h2b6; // arbitrary value
   localparam logic [31:0] ID_EXP = {REV, PART, MAKER, 1'b1};
   localparam logic [127:0] PAT = 128'h1c3ba5978d6f4e210fa83cd796b1e5d2;
   logic clk, rst_n, tck, tms, tdi, tdo, tdo_oe, extest, q_en, tdo_prev;
   logic [BSR_W-1:0] pins, bsr_drive;
   logic [127:0] d, o;
   logic [2:0] capt;
   int fails;
   int n_compared;
   // clk edges with tdo enabled, for span checks around a scan
   int oe_cnt = 0;
   int oe0;
   jtap_top #(.ID_REV(REV), .ID_PART(PART), .ID_MAKER(MAKER)) u_jtap_top (
      .clk_i(clk), .rst_n_i(rst_n), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
      .tdo_o(tdo), .tdo_oe_o(tdo_oe), .pins_i(pins),
      .bsr_drive_o(bsr_drive), .extest_o(extest), .q_drive_en_o(q_en));
   jtap_tester u_jtap_tester (.clk_i(clk), .tdo_i(tdo), .tck_o(tck),
      .tms_o(tms), .tdi_o(tdi));
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [127:0] seen, input logic [127:0] exp,
                        input string what);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check
   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : give_verdict
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (rst_n && tdo !== tdo_prev) begin
         check(tck, 1'b0, "tdo moved, tck high");
      end
      tdo_prev <= tdo;
      oe_cnt <= oe_cnt + (tdo_oe === 1'b1);
   end
   // whole run is near 3900 clk; this leaves ample margin
   initial begin
      #1000000;
      fails++;
      $display("BAD %0t watchdog expired", $time);
      give_verdict();
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      pins = 107'h2d1e2c3b4a5968778695a4b3c2d;
      fails = 0;
      n_compared = 0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      check(extest, 1'b0, "extest after reset");
      check(q_en, 1'b1, "drivers after reset");
      check(bsr_drive, 107'h1 << OE_CELL, "latch after reset");
      u_jtap_tester.to_idle();
      oe0 = oe_cnt;
      u_jtap_tester.scan(1'b0, 34, 128'h2, o);
      check(o[31:0], ID_EXP, "identity word");
      check(o[33:32], 2'h2, "identity length");
      // one link period is 8 clk; enabled for each shift state fall
      check(oe_cnt - oe0, 8 * 34, "tdo enable span");
      check(tdo_oe, 1'b0, "tdo enable idle");
      oe0 = oe_cnt;
      u_jtap_tester.load_ir(IR_BYPASS, capt);
      check(capt, 3'h1, "ir capture");
      check(oe_cnt - oe0, 8 * IR_W, "ir enable span");
      u_jtap_tester.scan(1'b0, 4, 128'hb, o);
      check(o[3:0], 4'h6, "skip register");
      u_jtap_tester.load_ir(IR_SAMPLE, capt);
      check({extest, q_en}, 2'h1, "sample mode");
      d = PAT & ~(128'h1 << 49);
      u_jtap_tester.scan(1'b0, 109, d, o);
      check(o[106:0], pins, "sample capture");
      check(o[108:107], d[1:0], "chain length");
      check(bsr_drive, d[108:2], "chain order");
      u_jtap_tester.load_ir(IR_EXTEST, capt);
      check({extest, q_en}, 2'h2, "cell 47 low floats");
      pins <= ~pins;
      d = ~PAT | (128'h1 << 47);
      u_jtap_tester.scan(1'b0, 107, d, o);
      check(o[106:0], pins, "extest capture");
      check(bsr_drive, d[106:0], "extest latch");
      check(q_en, 1'b1, "cell 47 high drives");
      u_jtap_tester.load_ir(IR_SAMPLEZ, capt);
      check({extest, q_en}, 2'h0, "floating sample");
      d = PAT & ~(128'h1 << 47);
      u_jtap_tester.scan(1'b0, 107, d, o);
      check(o[106:0], pins, "floating capture");
      u_jtap_tester.load_ir(IR_EXTEST, capt);
      check(q_en, 1'b0, "latched cell 47 low");
      u_jtap_tester.to_idle();
      check({extest, q_en, bsr_drive[OE_CELL]}, 3'h3, "reset");
      u_jtap_tester.scan(1'b0, 32, 128'h0, o);
      check(o[31:0], {REV, PART, MAKER, 1'b1}, "identity again");
      give_verdict();
   end
endmodule : jtap_top_tb
`default_nettype wire
